// ===== logic/cmb_msg_buffer.sv
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // transmit bit stream
  input  wire logic        TX_ADV,
  output logic             TX_BIT,
  output logic             TX_ACTIVE,
  output logic             TX_DONE,
  // receive bit stream
  input  wire logic        RX_SOF,
  input  wire logic        RX_VALID,
  input  wire logic        RX_BIT,
  // status
  output logic             RX_FULL,
  output logic             ARB_LOST
);
  cmb_pkg::cmb_main_t q;
  cmb_pkg::cmb_main_t n;

  // decoded receive frame
  logic             rx_done;
  logic             rx_ide;
  logic             rx_rtr;
  logic             rx_srr;
  logic [28:0]      rx_id;
  logic [3:0]       rx_dlc;
  logic [0:7][7:0]  rx_data;

  // transmit frame assembly
  logic             ide_sel;
  logic             rtr_sel;
  logic [3:0]       nb_sel;
  logic [6:0]       hdr_bits;
  logic [5:0]       arb_bits;
  logic [6:0]       frame_len;
  logic [31:0]      hdr_vec;
  logic [99:0]      tail_vec;
  logic [99:0]      frame_vec;

  // apb decode
  logic             acc;
  logic             wr;
  logic             rd;
  logic             in_data;
  logic [2:0]       di;
  logic             mapped;
  logic             go;
  logic [31:0]      rdata;

  cmb_rx_deser u_rx (
    .clk      (CLK),
    .rst_n    (RST_N),
    .rx_sof   (RX_SOF),
    .rx_valid (RX_VALID),
    .rx_bit   (RX_BIT),
    .done     (rx_done),
    .ide      (rx_ide),
    .rtr      (rx_rtr),
    .srr      (rx_srr),
    .id       (rx_id),
    .length_code      (rx_dlc),
    .data     (rx_data)
  );

  assign ide_sel = q.id1[cmb_pkg::IDE_POS];
  assign rtr_sel = ide_sel ? q.id3[0] : q.id1[cmb_pkg::RTR_POS];

  // a code past eight still moves only eight bytes
  always_comb begin
    if (rtr_sel) begin
      nb_sel = 4'h0;
    end else if (q.len > cmb_pkg::MAX_BYTES) begin
      nb_sel = cmb_pkg::MAX_BYTES;
    end else begin
      nb_sel = q.len;
    end
  end

  assign hdr_bits = ide_sel ? cmb_pkg::EXT_HDR_BITS
                            : cmb_pkg::STD_HDR_BITS;
  assign arb_bits = ide_sel ? cmb_pkg::EXT_ARB_BITS
                            : cmb_pkg::STD_ARB_BITS;
  assign frame_len = hdr_bits + cmb_pkg::LEN_BITS
                   + {nb_sel, 3'b000};
  // standard header: id10..id3, id2..id0, remote, extension
  assign hdr_vec = ide_sel ? {q.id0, q.id1, q.id2, q.id3}
                           : {q.id0, q.id1[7:3], 19'h0};
  // length code always sent as programmed
  assign tail_vec  = {q.len, q.dat, 32'h0};
  assign frame_vec = {hdr_vec, 68'h0} | (tail_vec >> hdr_bits);

  assign acc     = PSEL && PENABLE && !q.pready;
  assign wr      = acc && PWRITE;
  assign rd      = acc && !PWRITE;
  assign in_data = PADDR >= cmb_pkg::OFF_DATA0
                && PADDR <= cmb_pkg::OFF_DATA7
                && PADDR[1:0] == 2'b00;
  assign di      = 3'(PADDR[5:2] - cmb_pkg::OFF_DATA0[5:2]);
  assign mapped  = PADDR[1:0] == 2'b00 && PADDR <= cmb_pkg::OFF_STAT;
  assign go      = wr && PADDR == cmb_pkg::OFF_CTRL
                && PWDATA[cmb_pkg::GO_POS] && !q.busy;

  always_comb begin
    rdata = 32'h0;
    if (in_data) begin
      rdata = {24'h0, q.dat[di]};
    end else begin
      case (PADDR)
        cmb_pkg::OFF_ID_HI: rdata = {24'h0, q.id0};
        // low bits of the second register and the two upper
        // registers carry no standard meaning
        cmb_pkg::OFF_ID_LO: rdata = {24'h0, q.id1};
        cmb_pkg::OFF_ID_2:  rdata = {24'h0, q.id2};
        cmb_pkg::OFF_ID_3:  rdata = {24'h0, q.id3};
        cmb_pkg::OFF_LEN:   rdata = {28'h0, q.len};
        cmb_pkg::OFF_STAT: begin
          rdata[cmb_pkg::BUSY_POS] = q.busy;
          rdata[cmb_pkg::RXF_POS]  = q.rxf;
          rdata[cmb_pkg::LOST_POS] = q.lost;
        end
        default: rdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    n = q;
    n.tx_done = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    // clears first, so a loss in the same cycle still sets
    if (wr && PADDR == cmb_pkg::OFF_STAT) begin
      if (PWDATA[cmb_pkg::RXF_POS]) begin
        n.rxf = 1'b0;
      end
      if (PWDATA[cmb_pkg::LOST_POS]) begin
        n.lost = 1'b0;
      end
    end

    // transmit shifter
    if (q.busy && TX_ADV) begin
      if (q.arb != 6'h0 && q.frm[99] && !RX_BIT) begin
        // recessive sent, dominant seen: lower id elsewhere wins
        n.busy = 1'b0;
        n.lost = 1'b1;
      end else if (q.left == 7'h01) begin
        n.busy = 1'b0;
        n.tx_done = 1'b1;
      end else begin
        n.frm  = {q.frm[98:0], 1'b0};
        n.left = q.left - 7'h01;
        if (q.arb != 6'h0) begin
          n.arb = q.arb - 6'h01;
        end
      end
    end

    // register access, three cycles per transfer
    if (acc) begin
      n.pready  = 1'b1;
      n.pslverr = !mapped;
      n.prdata  = rd ? rdata : 32'h0;
    end
    // buffer is locked while its frame is on the bus
    if (wr && !q.busy) begin
      if (in_data) begin
        n.dat[di] = PWDATA[7:0];
      end
      case (PADDR)
        cmb_pkg::OFF_ID_HI: n.id0 = PWDATA[7:0];
        cmb_pkg::OFF_ID_LO: n.id1 = PWDATA[7:0];
        cmb_pkg::OFF_ID_2:  n.id2 = PWDATA[7:0];
        cmb_pkg::OFF_ID_3:  n.id3 = PWDATA[7:0];
        cmb_pkg::OFF_LEN:   n.len = PWDATA[3:0];
        default: n.len = n.len;
      endcase
    end
    if (go) begin
      n.busy = 1'b1;
      n.frm  = frame_vec;
      n.left = frame_len;
      n.arb  = arb_bits;
      n.lost = 1'b0;
    end

    // received frame, dropped while busy or on go; otherwise store wins over a same-cycle write or clear
    if (rx_done && !q.busy && !go) begin
      n.rxf = 1'b1;
      n.len = rx_dlc;
      n.dat = rx_data;
      if (rx_ide) begin
        n.id0 = rx_id[28:21];
        n.id1 = {rx_id[20:18], rx_srr, 1'b1, rx_id[17:15]};
        n.id2 = rx_id[14:7];
        n.id3 = {rx_id[6:0], rx_rtr};
      end else begin
        n.id0 = rx_id[10:3];
        n.id1 = {rx_id[2:0], rx_rtr, 1'b0, q.id1[2:0]};
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '{id0: cmb_pkg::BUF_RST, id1: cmb_pkg::BUF_RST,
             id2: cmb_pkg::BUF_RST, id3: cmb_pkg::BUF_RST,
             dat: '0, len: 4'h0, busy: 1'b0, frm: '0, left: 7'h0,
             arb: 6'h0, lost: 1'b0, rxf: 1'b0, tx_done: 1'b0,
             pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};
    end else begin
      q <= n;
    end
  end

  assign PRDATA    = q.prdata;
  assign PREADY    = q.pready;
  assign PSLVERR   = q.pslverr;
  assign TX_BIT    = q.frm[99];
  assign TX_ACTIVE = q.busy;
  assign TX_DONE   = q.tx_done;
  assign RX_FULL   = q.rxf;
  assign ARB_LOST  = q.lost;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  AST_MSB_FIRST: assert property (
    go |=> TX_ACTIVE && TX_BIT == $past(q.id0[7]))
    else $error("first bit sent is not identifier bit ten");

  AST_ARB_LOSS: assert property (
    q.busy && TX_ADV && q.arb != 6'h0 && TX_BIT && !RX_BIT
    |=> !TX_ACTIVE && ARB_LOST && !TX_DONE)
    else $error("arbitration loss not taken");

  AST_ID_WRITE: assert property (
    wr && !q.busy && PADDR == cmb_pkg::OFF_ID_LO && !rx_done
    |=> q.id1[7:5] == $past(PWDATA[7:5]))
    else $error("low identifier bits not stored");

  AST_RX_STD: assert property (
    rx_done && !q.busy && !go && !rx_ide
    |=> RX_FULL && q.id1[4] == $past(rx_rtr) && !q.id1[3])
    else $error("received remote flag not stored");

  AST_STD_LEN: assert property (
    go && !rtr_sel && !ide_sel && q.len < 4'h9
    |=> q.left == 7'd17 + {$past(q.len), 3'b000})
    else $error("standard frame length wrong");

  AST_LEN_CAP: assert property (
    go && !rtr_sel && !ide_sel && q.len > 4'h8 |=> q.left == 7'd81)
    else $error("payload not capped at eight bytes");

  AST_REMOTE: assert property (
    go && rtr_sel |=> q.left == (ide_sel ? 7'd36 : 7'd17))
    else $error("remote frame carries payload");

  AST_EXT_FMT: assert property (
    go && ide_sel |=> q.arb == 6'd32
    && q.frm[99:68] == {$past(q.id0), $past(q.id1), $past(q.id2),
                        $past(q.id3)})
    else $error("extended format not chosen");

  AST_LEN_FIELD: assert property (
    wr && !q.busy && PADDR == cmb_pkg::OFF_LEN && !rx_done
    |=> q.len == $past(PWDATA[3:0]))
    else $error("length code not stored");

  AST_APB_ANSWER: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle later");

  AST_ID_HI_WRITE: assert property (
    wr && !q.busy && PADDR == cmb_pkg::OFF_ID_HI && !rx_done
    |=> q.id0 == $past(PWDATA[7:0]))
    else $error("high identifier byte not stored");

  AST_RTR_BIT: assert property (
    go && !ide_sel |=> q.frm[88] == $past(q.id1[cmb_pkg::RTR_POS]))
    else $error("remote flag not in its frame slot");

  // extension flag lands in the same frame slot in both formats
  AST_IDE_BIT: assert property (
    go |=> q.frm[87] == $past(q.id1[cmb_pkg::IDE_POS]))
    else $error("extension flag not in its frame slot");

  AST_RX_EXT: assert property (
    rx_done && !q.busy && !go && rx_ide
    |=> RX_FULL && q.id1[3] && q.id3[0] == $past(rx_rtr))
    else $error("extended frame not stored as received");

  AST_SHIFT: assert property (
    q.busy && TX_ADV && q.left > 7'h01
    && (q.arb == 6'h0 || !q.frm[99] || RX_BIT)
    |=> TX_ACTIVE && TX_BIT == $past(q.frm[98]))
    else $error("next frame bit not presented");

  AST_LAST_BIT: assert property (
    q.busy && TX_ADV && q.left == 7'h01 && q.arb == 6'h0
    |=> TX_DONE && !TX_ACTIVE ##1 !TX_DONE)
    else $error("frame end not flagged for one cycle");

  AST_DATA_WRITE: assert property (
    wr && !q.busy && in_data && !rx_done
    |=> q.dat[$past(di)] == $past(PWDATA[7:0]))
    else $error("payload byte not stored");

  AST_RX_LEN: assert property (
    rx_done && !q.busy && !go |=> q.len == $past(rx_dlc))
    else $error("received length code not stored");

  AST_RD_LEN: assert property (
    rd && PADDR == cmb_pkg::OFF_LEN |=> PRDATA == {28'h0, $past(q.len)})
    else $error("length register read wrong");
endmodule
`default_nettype wire

// ===== logic/cmb_pkg.sv
`default_nettype none
package cmb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_ID_HI  = 8'h00;
  localparam logic [7:0] OFF_ID_LO  = 8'h04;
  localparam logic [7:0] OFF_ID_2   = 8'h08;
  localparam logic [7:0] OFF_ID_3   = 8'h0C;
  localparam logic [7:0] OFF_DATA0  = 8'h10;
  localparam logic [7:0] OFF_DATA7  = 8'h2C;
  localparam logic [7:0] OFF_LEN    = 8'h30;
  localparam logic [7:0] OFF_CTRL   = 8'h34;
  localparam logic [7:0] OFF_STAT   = 8'h38;
  // field positions
  localparam int ID_LO_POS  = 5;
  localparam int RTR_POS    = 4;
  localparam int IDE_POS    = 3;
  localparam int GO_POS     = 0;
  localparam int BUSY_POS   = 0;
  localparam int RXF_POS    = 1;
  localparam int LOST_POS   = 2;
  // reset values
  localparam logic [7:0] BUF_RST = 8'h00;
  // frame geometry, in bits; the payload cap in bytes
  localparam logic [3:0] MAX_BYTES    = 4'h8;
  localparam logic [6:0] STD_HDR_BITS = 7'h0D;
  localparam logic [6:0] EXT_HDR_BITS = 7'h20;
  localparam logic [5:0] STD_ARB_BITS = 6'h0C;
  localparam logic [5:0] EXT_ARB_BITS = 6'h20;
  localparam logic [6:0] LEN_BITS     = 7'h04;
  localparam logic [6:0] IDE_IDX      = 7'h0C;
  localparam logic [6:0] FRAME_MAX    = 7'h64;

  typedef struct packed {
    logic [99:0] sh;
    logic [6:0]  cnt;
    logic [6:0]  total;
    logic        ide;
    logic [3:0]  nb;
    logic        done;
  } cmb_rx_t;

  typedef struct packed {
    logic [7:0]       id0;
    logic [7:0]       id1;
    logic [7:0]       id2;
    logic [7:0]       id3;
    logic [0:7][7:0]  dat;
    logic [3:0]       len;
    logic             busy;
    logic [99:0]      frm;
    logic [6:0]       left;
    logic [5:0]       arb;
    logic             lost;
    logic             rxf;
    logic             tx_done;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } cmb_main_t;
endpackage
`default_nettype wire

// ===== logic/cmb_rx_deser.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_rx_deser (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // received bit stream
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic        rx_bit,
  // decoded frame
  output logic             done,
  output logic             ide,
  output logic             rtr,
  output logic             srr,
  output logic [28:0]      id,
  output logic [3:0]       length_code,
  output logic [0:7][7:0]  data
);
  cmb_pkg::cmb_rx_t q;
  cmb_pkg::cmb_rx_t n;
  logic [99:0] hd;
  logic [6:0]  hdr;

  assign hdr  = q.ide ? cmb_pkg::EXT_HDR_BITS : cmb_pkg::STD_HDR_BITS;
  assign hd   = q.sh >> {q.nb, 3'b000};
  assign done = q.done;
  assign ide  = q.ide;
  assign length_code  = hd[3:0];
  assign srr  = hd[24];
  assign rtr  = q.ide ? hd[4] : hd[5];
  assign id   = q.ide ? {hd[35:25], hd[22:5]} : {18'h0, hd[16:6]};
  assign data = q.sh[63:0] << {4'h8 - q.nb, 3'b000};

  always_comb begin
    logic [3:0] code;
    logic       r;
    code = 4'h0;
    r = 1'b0;
    n = q;
    n.done = 1'b0;
    if (rx_sof) begin
      n.sh = '0;
      n.cnt = '0;
      n.total = cmb_pkg::FRAME_MAX;
      n.ide = 1'b0;
      n.nb = 4'h0;
    end else if (rx_valid && q.cnt < q.total) begin
      n.sh = {q.sh[98:0], rx_bit};
      n.cnt = q.cnt + 7'h01;
      if (q.cnt == cmb_pkg::IDE_IDX) begin
        n.ide = rx_bit;
      end
      if (q.cnt == hdr + 7'h03) begin
        code = {q.sh[2:0], rx_bit};
        r = q.ide ? q.sh[3] : q.sh[4];
        // payload as long as the code says, capped at eight, none for a remote frame
        if (r) begin
          n.nb = 4'h0;
        end else if (code > cmb_pkg::MAX_BYTES) begin
          n.nb = cmb_pkg::MAX_BYTES;
        end else begin
          n.nb = code;
        end
        n.total = hdr + cmb_pkg::LEN_BITS + {n.nb, 3'b000};
      end
      n.done = (n.cnt == n.total);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{sh: '0, cnt: '0, total: cmb_pkg::FRAME_MAX, ide: 1'b0,
             nb: 4'h0, done: 1'b0};
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/cmb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_bus_model (
  // link to the buffer
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tx_bit,
  input  wire logic tx_active,
  output logic      tx_adv,
  output logic      rx_sof,
  output logic      rx_valid,
  output logic      rx_bit
);
  logic [99:0] cap;
  logic [99:0] rival;
  logic        rival_on;
  logic        slow;
  logic        rx_on;
  logic        rx_drv;
  int          ncap;

  initial begin
    tx_adv = 1'b0;
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_on = 1'b0;
    rx_drv = 1'b1;
    rival_on = 1'b0;
    slow = 1'b0;
    ncap = 0;
    cap = '0;
    rival = '1;
  end

  // wired-and bus, idle recessive; a rival node drives its own header
  always_comb begin
    if (rx_on) rx_bit = rx_drv;
    else if (tx_active && rival_on && ncap < 100)
      rx_bit = tx_bit & rival[99-ncap];
    else if (tx_active) rx_bit = tx_bit;
    else rx_bit = 1'b1;
  end

  // slow mode advances every other cycle
  always @(posedge clk) begin
    if (tx_adv && tx_active && ncap < 100) begin
      cap[99-ncap] <= tx_bit;
      ncap <= ncap + 1;
      // rival backs off once it sees a dominant bit it did not send
      if (rival_on && rx_bit !== rival[99-ncap]) rival_on <= 1'b0;
    end
    tx_adv <= rst_n && tx_active && !(slow && tx_adv);
  end

  task automatic send(input logic [99:0] b, input int n);
    @(posedge clk);
    rx_sof <= 1'b1;
    rx_on  <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_sof   <= 1'b0;
      rx_valid <= 1'b1;
      rx_drv   <= b[99-i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_on    <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/cmb_msg_buffer_test.sv
`timescale 1ns/1ps
`default_nettype none
module cmb_msg_buffer_test;
  logic        CLK;
  logic        RST_N;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        TX_ADV;
  logic        TX_BIT;
  logic        TX_ACTIVE;
  logic        TX_DONE;
  logic        RX_SOF;
  logic        RX_VALID;
  logic        RX_BIT;
  logic        RX_FULL;
  logic        ARB_LOST;
  logic [31:0] q;
  logic        e;
  logic [63:0] pay = 64'h0123_4567_89AB_CDEF;
  int          n_fail = 0;
  int          cmp_count = 0;

  cmb_msg_buffer uut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_ADV(TX_ADV),
    .TX_BIT(TX_BIT), .TX_ACTIVE(TX_ACTIVE), .TX_DONE(TX_DONE),
    .RX_SOF(RX_SOF), .RX_VALID(RX_VALID), .RX_BIT(RX_BIT),
    .RX_FULL(RX_FULL), .ARB_LOST(ARB_LOST));

  cmb_bus_model bus (.clk(CLK), .rst_n(RST_N), .tx_bit(TX_BIT),
    .tx_active(TX_ACTIVE), .tx_adv(TX_ADV), .rx_sof(RX_SOF),
    .rx_valid(RX_VALID), .rx_bit(RX_BIT));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic finish_test;
    $display("mismatches %0d, compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [99:0] seen, input logic [99:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask

  // idle edge first, so a release and the next setup never share a step
  task automatic apb(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr_en;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      finish_test();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic ee,
                        input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({e, q}, {ee, exp});
  endtask

  // expected bit sequence, first bit in the top position
  function automatic logic [99:0] frame(input logic [31:0] h, input int hb,
      input logic [3:0] c, input int nb, input logic [63:0] p);
    logic [99:0] v;
    int          k;
    v = '0;
    k = 99;
    for (int i = hb - 1; i >= 0; i--) begin
      v[k] = h[i];
      k--;
    end
    for (int i = 3; i >= 0; i--) begin
      v[k] = c[i];
      k--;
    end
    for (int i = 63; i >= 64 - 8 * nb; i--) begin
      v[k] = p[i];
      k--;
    end
    return v;
  endfunction

  task automatic do_tx(input logic [31:0] h, input int hb,
      input logic [3:0] c, input int nb, input logic win);
    int   k;
    logic done;
    logic lost;
    if (hb == 13) begin
      wr(cmb_pkg::OFF_ID_HI, {24'h0, h[12:5]});
      wr(cmb_pkg::OFF_ID_LO, {24'h0, h[4:0], 3'h0});
    end else begin
      for (int i = 0; i < 4; i++)
        wr(cmb_pkg::OFF_ID_HI + 8'(4 * i), {24'h0, h[31-8*i -: 8]});
    end
    for (int i = 0; i < 8; i++)
      wr(cmb_pkg::OFF_DATA0 + 8'(4 * i), {24'h0, pay[63-8*i -: 8]});
    wr(cmb_pkg::OFF_LEN, {28'h0, c});
    bus.cap = '0;
    bus.ncap = 0;
    bus.rival_on = 1'b1;
    wr(cmb_pkg::OFF_CTRL, 32'h1);
    k = 0;
    done = 1'b0;
    lost = 1'b0;
    while (!done && !lost && k < 2000) begin
      @(posedge CLK);
      k++;
      done = (TX_DONE === 1'b1);
      lost = (ARB_LOST === 1'b1);
    end
    chk({done, lost, TX_ACTIVE}, {win, !win, 1'b0});
    if (!done && !lost) begin
      finish_test();
    end
    if (win) begin
      chk(bus.cap, frame(h, hb, c, nb, pay));
      chk(bus.ncap, hb + 4 + 8 * nb);
    end
  endtask

  task automatic do_rx(input logic [31:0] h, input int hb,
      input logic [3:0] c, input int nb);
    int k;
    bus.send(frame(h, hb, c, nb, pay), hb + 4 + 8 * nb);
    k = 0;
    while (RX_FULL !== 1'b1 && k < 20) begin
      @(posedge CLK);
      k++;
    end
    chk(RX_FULL, 1'b1);
    if (RX_FULL !== 1'b1) begin
      finish_test();
    end
    if (hb == 13) begin
      rd_chk(cmb_pkg::OFF_ID_HI, 1'b0, {24'h0, h[12:5]});
      apb(1'b0, cmb_pkg::OFF_ID_LO, 32'h0);
      chk(q[7:3], h[4:0]);
    end else begin
      for (int i = 0; i < 4; i++)
        rd_chk(cmb_pkg::OFF_ID_HI + 8'(4 * i), 1'b0,
               {24'h0, h[31-8*i -: 8]});
    end
    for (int i = 0; i < 8; i++)
      rd_chk(cmb_pkg::OFF_DATA0 + 8'(4 * i), 1'b0,
             i < nb ? {24'h0, pay[63-8*i -: 8]} : 32'h0);
    rd_chk(cmb_pkg::OFF_LEN, 1'b0, {28'h0, c});
    wr(cmb_pkg::OFF_STAT, 32'h2);
    chk(RX_FULL, 1'b0);
  endtask

  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    rd_chk(cmb_pkg::OFF_ID_HI, 1'b0, 32'h0);
    rd_chk(8'h3C, 1'b1, 32'h0);
    rd_chk(8'h05, 1'b1, 32'h0);
    wr(cmb_pkg::OFF_ID_LO, 32'hFFFF_FFFF);
    rd_chk(cmb_pkg::OFF_ID_LO, 1'b0, 32'hFF);
    wr(cmb_pkg::OFF_LEN, 32'hFFFF_FFFF);
    rd_chk(cmb_pkg::OFF_LEN, 1'b0, 32'h0F);
    for (int i = 0; i < 8; i++) begin
      wr(cmb_pkg::OFF_DATA0 + 8'(4 * i), {24'h0, 8'(37 * i + 5)});
      rd_chk(cmb_pkg::OFF_DATA0 + 8'(4 * i), 1'b0,
             {24'h0, 8'(37 * i + 5)});
    end
    // unaligned payload access refused, byte zero untouched
    wr(8'h11, 32'hAA);
    rd_chk(8'h11, 1'b1, 32'h0);
    rd_chk(cmb_pkg::OFF_DATA0, 1'b0, 32'h05);
    // every length code, codes above eight capped, half of them stalled
    for (int c = 0; c < 16; c++) begin
      bus.slow = c[0];
      do_tx({19'h0, 11'h5A3, 2'b00}, 13, 4'(c), c > 8 ? 8 : c, 1'b1);
    end
    bus.slow = 1'b0;
    do_tx({19'h0, 11'h5A3, 2'b10}, 13, 4'h5, 0, 1'b1);
    do_tx(32'hC35E_91A6, 32, 4'h2, 2, 1'b1);
    bus.rival = frame({19'h0, 11'h5A2, 2'b00}, 13, 4'h1, 0, pay);
    do_tx({19'h0, 11'h5A3, 2'b00}, 13, 4'h1, 1, 1'b0);
    rd_chk(cmb_pkg::OFF_STAT, 1'b0, 32'h4);
    bus.rival = frame({19'h0, 11'h5A4, 2'b00}, 13, 4'h1, 0, pay);
    do_tx({19'h0, 11'h5A3, 2'b00}, 13, 4'h1, 1, 1'b1);
    bus.rival = '1;
    do_rx({19'h0, 11'h123, 2'b10}, 13, 4'h2, 0);
    do_rx(32'hA51F_C3E6, 32, 4'h3, 3);
    finish_test();
  end
endmodule
`default_nettype wire
